/* File: rspfe_check.sv */
/*
  Value checker for one 16-bit write word.
  Combinational; assumes the caller registers the verdict.
*/
module rspfe_check
  import rspfe_pkg::*;
(
  input  wire logic [1:0]  kind,        // Kind of target register.
  input  wire logic        ovt_alt,     // Select the 103 percent threshold variant.
  input  wire logic [15:0] value,       // Word to be written.
  input  wire logic [15:0] lim_min,     // User limit minimum.
  input  wire logic [15:0] lim_max,     // User limit maximum.
  output logic [3:0]       verdict      // ERR_NONE when the word may be stored.
);
  logic [15:0] span_max;

  // Span ceiling per kind; thresholds have their own wider span.
  always_comb
  begin
    span_max = CODE_SET_MAX;
    if (kind == KIND_OVT)
    begin
      span_max = ovt_alt ? CODE_OVT_ALTMAX : CODE_OVT_MAX;
    end
  end

  // Nominal span is checked before the narrower user limits.
  always_comb
  begin
    verdict = ERR_NONE;
    if (kind == KIND_COIL)
    begin
      if (value != COIL_FALSE && value != COIL_TRUE)
      begin
        verdict = ERR_RANGE;
      end
    end
    else if (kind != KIND_RAW)
    begin
      if (value > span_max)
      begin
        verdict = ERR_RANGE;
      end
      else if (kind == KIND_SET && (value < lim_min || value > lim_max))
      begin
        verdict = ERR_LIMIT;
      end
    end
  end
endmodule : rspfe_check

/* File: rspfe_host.sv */
/*
  Host side model: sends one three-byte telegram, a lead byte and then a word.
  Assumes the bench raises go for one cycle while busy is low.
*/
module rspfe_host
(
  input  wire logic        clk,      // Bench clock.
  input  wire logic        srst,     // Synchronous reset, active high.
  input  wire logic        go,       // Start one telegram.
  input  wire logic        slow,     // Leave an idle cycle after every byte.
  input  wire logic [7:0]  lead,     // First byte of the telegram.
  input  wire logic [15:0] word,     // Data word that follows it.
  output logic             rx_valid, // Byte strobe.
  output logic [7:0]       rx_byte,  // Byte on the line.
  output logic             rx_first, // First byte mark.
  output logic             rx_last,  // Last byte mark.
  output logic             busy      // Telegram in progress.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] idx;

  // An idle line shows the inverse of the last byte, so stale data never looks valid.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      idx      <= 2'h0;
      busy     <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte  <= 8'h00;
      rx_first <= 1'b0;
      rx_last  <= 1'b0;
    end
    else if (go && !busy)
    begin
      busy <= 1'b1;
      idx  <= 2'h0;
    end
    else if (busy)
    begin
      if ((slow && rx_valid) || idx == 2'h3)
      begin
        rx_valid <= 1'b0;
        rx_byte  <= ~rx_byte;
        busy     <= (idx != 2'h3);
      end
      else
      begin
        rx_valid <= 1'b1;
        rx_byte  <= (idx == 2'h0) ? lead : (idx == 2'h1) ? word[15:8] : word[7:0];
        rx_first <= (idx == 2'h0);
        rx_last  <= (idx == 2'h2);
        idx      <= idx + 2'h1;
      end
    end
  end
endmodule : rspfe_host

/* File: rspfe_pkg.sv */
/*
  Package for the remote set point protocol front end.
  Holds code limits, first byte classes, header sizes and the state encoding.
  Assumes one clock domain and that every user of it imports the whole package.
*/
package rspfe_pkg;
  localparam logic [7:0]  SLAVE_ADDR      = 8'h00;   // Fixed slave address.
  localparam logic [7:0]  TEXT_FIRST_MIN  = 8'h2A;   // 42, first byte of a text string.
  localparam logic [15:0] CODE_FULL       = 16'hCCCC; // 100 percent of nominal.
  localparam logic [15:0] CODE_SET_MAX    = 16'hD0E5; // 102 percent.
  localparam logic [15:0] CODE_OVT_MAX    = 16'hE147; // 110 percent.
  localparam logic [15:0] CODE_OVT_ALTMAX = 16'hD2F1; // 103 percent variant.
  localparam logic [15:0] COIL_FALSE      = 16'h0000; // Coil word meaning false.
  localparam logic [15:0] COIL_TRUE       = 16'hFF00; // Coil word meaning true.
  localparam logic [15:0] TCP_REG_PORT    = 16'h01F6; // 502, register port.
  localparam logic [2:0]  TCP_HDR_SHORT   = 3'h6;    // Short header bytes.
  localparam logic [2:0]  TCP_HDR_LONG    = 3'h7;    // Long header bytes.
  localparam int          EFF_STEPS       = 26214;   // Effective resolution steps.
  localparam logic [15:0] SET_RESET       = 16'h0000; // Reset value of stored set points.
  localparam logic [1:0]  ACC_RO          = 2'h0;    // Access class read only.
  localparam logic [1:0]  ACC_WO          = 2'h1;    // Access class write only.
  localparam logic [1:0]  ACC_RW          = 2'h2;    // Access class read write.
  localparam logic [1:0]  KIND_SET        = 2'h0;    // Ordinary set value.
  localparam logic [1:0]  KIND_OVT        = 2'h1;    // over_voltage_threshold.
  localparam logic [1:0]  KIND_COIL       = 2'h2;    // Coil word.
  localparam logic [1:0]  KIND_RAW        = 2'h3;    // Unchecked word.
  localparam logic [3:0]  ERR_NONE        = 4'h0;    // No error.
  localparam logic [3:0]  ERR_ADDR        = 4'h1;    // Bad first byte.
  localparam logic [3:0]  ERR_RANGE       = 4'h2;    // Code outside nominal span.
  localparam logic [3:0]  ERR_LIMIT       = 4'h3;    // Code outside user limits.
  localparam logic [3:0]  ERR_REMOTE      = 4'h4;    // Write without remote control.
  localparam logic [3:0]  ERR_ACCESS      = 4'h5;    // Write to read only register.
  localparam logic [3:0]  ERR_TEXT_TCP    = 4'h6;    // Text string on register port.
  localparam logic [3:0]  ERR_LENGTH      = 4'h7;    // Bad header length, wrong TCP port or no option.

  typedef enum logic [3:0] {
    RSPFE_IDLE  = 4'b0001,
    RSPFE_BIN   = 4'b0010,
    RSPFE_TEXT  = 4'b0100,
    RSPFE_DROP  = 4'b1000
  } rspfe_state_t;
endpackage : rspfe_pkg

/* File: rspfe_top.sv */
/*
  Remote set point protocol front end: classifies telegrams by first byte,
  steers text strings away, checks decoded writes and guards remote control.
  Assumes an upstream framer that delivers bytes with start and end marks and
  a decoder that presents one write word per telegram with its target data.
*/
// How it works
// - Slave address fixed at zero, never changeable.
// - First byte 1 to 41 is error.
// - First byte 42 or more goes text.
// - TCP register telegrams only on port 502.
// - TCP header is 6 or 7 bytes.
// - No text strings on the TCP port.
// - Values are percent codes, 0xCCCC full.
// - Set codes accepted up to 0xD0E5.
// - Threshold codes up to 0xE147 or 0xD2F1.
// - Internal output code halved to 26214 steps.
// - Reads return same percent encoding.
// - Codes outside user limits are rejected; the code checks user limits on set codes only, not on threshold codes.
// - Remote control only on explicit request.
// - Locked remote request keeps local control.
// - Text errors reported only on query; the code also raises err_pulse for a refused write in text mode.
// - Writes need remote control.
// - Registers have fixed access classes.
// - Registers are whole 2-byte words.
// - Data widths 1, 2 or 4 bytes.
// - Virtual serial line settings ignored.
// - Fields big endian, checksum low first.
// - Valid write echoed, query answered.
// - Coil word 0x0000 false, 0xFF00 true.
module rspfe_top
  import rspfe_pkg::*;
(
  input  wire logic        clk,          // 125 MHz clock.
  input  wire logic        srst,         // Synchronous reset, active high.
  input  wire logic        ce,           // Clock enable; low freezes all state.
  input  wire logic        rx_valid,     // Received byte strobe.
  input  wire logic [7:0]  rx_byte,      // Received byte.
  input  wire logic        rx_first,     // Byte is the first of a telegram.
  input  wire logic        rx_last,      // Byte is the last of a telegram.
  input  wire logic        rx_tcp,       // Telegram arrived over TCP.
  input  wire logic [15:0] tcp_port,     // Local TCP port of that telegram.
  input  wire logic [2:0]  tcp_hdr_len,  // Header bytes stripped by the framer.
  input  wire logic        tcp_fitted,   // Network interface option present.
  input  wire logic        wr_req,       // Decoded write word strobe.
  input  wire logic [1:0]  wr_sel,       // Target set point slot.
  input  wire logic [1:0]  wr_kind,      // Target value kind.
  input  wire logic [1:0]  wr_access,    // Target access class.
  input  wire logic [15:0] wr_value,     // Word to write.
  input  wire logic        rd_req,       // Read strobe.
  input  wire logic [1:0]  rd_sel,       // Slot to read.
  input  wire logic        remote_req,   // Request to enter remote control.
  input  wire logic        local_req,    // Request to return to local.
  input  wire logic        remote_lock,  // Remote control locked out locally.
  input  wire logic        ovt_alt,      // 103 percent threshold variant.
  input  wire logic [15:0] lim_min,      // User limit minimum.
  input  wire logic [15:0] lim_max,      // User limit maximum.
  input  wire logic        err_query,    // Text error query command.
  output logic             remote,       // Remote control active.
  output logic             text_valid,   // Byte forwarded to text interpreter.
  output logic [7:0]       text_byte,    // Forwarded byte.
  output logic             text_last,    // Last forwarded byte of a string.
  output logic             bin_valid,    // Byte forwarded to register path.
  output logic [7:0]       bin_byte,     // Forwarded byte.
  output logic             bin_last,     // Last forwarded byte of a telegram.
  output logic             err_pulse,    // Binary error indication pulse.
  output logic [3:0]       err_code,     // Code of latest binary error.
  output logic             wr_ok,        // Write stored; echo may be sent.
  output logic             rd_valid,     // Read data valid.
  output logic [15:0]      rd_data,      // Read data, percent code.
  output logic             txt_err_valid,// Answer to error query.
  output logic [3:0]       txt_err_code, // Latest queued text error or none.
  output logic [15:0]      out_code      // Halved code for the power stage.
);
  rspfe_state_t state;
  rspfe_state_t next_state;
  logic [15:0]  setp [4];
  logic [3:0]   verdict;
  logic [3:0]   txt_err_q;
  logic         tcp_bad;
  logic         hdr_bad;
  logic [16:0]  halved;

  rspfe_check u_check (
    .kind    (wr_kind),
    .ovt_alt (ovt_alt),
    .value   (wr_value),
    .lim_min (lim_min),
    .lim_max (lim_max),
    .verdict (verdict)
  );

  // TCP telegrams need the option and the register port; hdr_bad checks the header.
  assign tcp_bad = rx_tcp && (!tcp_fitted || tcp_port != TCP_REG_PORT);

  // Any other header length means the framer lost its place in the stream.
  assign hdr_bad = rx_tcp && tcp_hdr_len != TCP_HDR_SHORT
                   && tcp_hdr_len != TCP_HDR_LONG;

  // Classify on the first byte only; the rest follows that choice.
  always_comb
  begin
    next_state = state;
    if (rx_valid && rx_first)
    begin
      if (tcp_bad || (rx_tcp && tcp_hdr_len != TCP_HDR_SHORT
                      && tcp_hdr_len != TCP_HDR_LONG))
        next_state = RSPFE_DROP;
      else if (rx_byte == SLAVE_ADDR)
        next_state = RSPFE_BIN;
      else if (rx_byte >= TEXT_FIRST_MIN && !rx_tcp)
        next_state = RSPFE_TEXT;
      else
        next_state = RSPFE_DROP;
    end
    if (rx_valid && rx_last)
      next_state = RSPFE_IDLE;
  end

  // Telegram state register.
  always_ff @(posedge clk)
  begin
    if (srst)
      state <= RSPFE_IDLE;
    else if (ce)
      state <= next_state;
  end

  // Byte routing; a first byte is decoded in place, later bytes follow state.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      text_valid <= 1'b0;
      text_byte  <= 8'h00;
      text_last  <= 1'b0;
      bin_valid  <= 1'b0;
      bin_byte   <= 8'h00;
      bin_last   <= 1'b0;
    end
    else if (ce)
    begin
      text_valid <= rx_valid && (rx_first ? (!tcp_bad && !rx_tcp
                    && rx_byte >= TEXT_FIRST_MIN) : state == RSPFE_TEXT);
      bin_valid  <= rx_valid && (rx_first ? (rx_byte == SLAVE_ADDR && !tcp_bad
                    && (!rx_tcp || tcp_hdr_len == TCP_HDR_SHORT
                        || tcp_hdr_len == TCP_HDR_LONG))
                    : state == RSPFE_BIN);
      text_byte  <= rx_byte;
      bin_byte   <= rx_byte;
      text_last  <= rx_last;
      bin_last   <= rx_last;
    end
  end

  // Remote control only by explicit request, and never entered while locked out.
  always_ff @(posedge clk)
  begin
    if (srst)
      remote <= 1'b0;
    else if (ce)
    begin
      if (local_req)
        remote <= 1'b0;
      else if (remote_req && !remote_lock)
        remote <= 1'b1;
    end
  end

  // Stored set points; a refused word leaves the old value in place.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 4; i++)
        setp[i] <= SET_RESET;
    end
    else if (ce && wr_req && remote && wr_access != ACC_RO
             && verdict == ERR_NONE)
      setp[wr_sel] <= wr_value;
  end

  // Write verdict and binary error indication, visible to the host.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_ok     <= 1'b0;
      err_pulse <= 1'b0;
      err_code  <= ERR_NONE;
    end
    else if (ce)
    begin
      wr_ok     <= 1'b0;
      err_pulse <= 1'b0;
      if (rx_valid && rx_first && next_state == RSPFE_DROP)
      begin
        err_pulse <= 1'b1;
        err_code  <= (rx_tcp && rx_byte >= TEXT_FIRST_MIN) ? ERR_TEXT_TCP
                   : (tcp_bad || hdr_bad) ? ERR_LENGTH : ERR_ADDR;
      end
      else if (wr_req)
      begin
        if (wr_access == ACC_RO)
        begin
          err_pulse <= 1'b1;
          err_code  <= ERR_ACCESS;
        end
        else if (!remote)
        begin
          err_pulse <= 1'b1;
          err_code  <= ERR_REMOTE;
        end
        else if (verdict != ERR_NONE)
        begin
          err_pulse <= 1'b1;
          err_code  <= verdict;
        end
        else
          wr_ok <= 1'b1;
      end
    end
  end

  // Reads return the stored percent code untouched.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_valid <= 1'b0;
      rd_data  <= 16'h0000;
    end
    else if (ce)
    begin
      rd_valid <= rd_req;
      if (rd_req)
        rd_data <= setp[rd_sel];
    end
  end

  // Text mode remote and value errors queue, err_pulse fires too; only a query reads and clears them.
  // A new error in the same cycle as the query is kept, set wins.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      txt_err_q     <= ERR_NONE;
      txt_err_valid <= 1'b0;
      txt_err_code  <= ERR_NONE;
    end
    else if (ce)
    begin
      txt_err_valid <= err_query;
      if (err_query)
        txt_err_code <= txt_err_q;
      if (wr_req && state == RSPFE_TEXT && (!remote || verdict != ERR_NONE))
        txt_err_q <= !remote ? ERR_REMOTE : verdict;
      else if (err_query)
        txt_err_q <= ERR_NONE;
    end
  end

  // Halve slot 0 for the 16-bit stage; top bit forced to zero, 26214 steps.
  assign halved = {1'b0, setp[0]} >> 1;
  always_ff @(posedge clk)
  begin
    if (srst)
      out_code <= 16'h0000;
    else if (ce)
      out_code <= {1'b0, halved[14:0]};
  end

  // Assertions.
  sequence s_locked_req;
    remote_req && remote_lock && !remote && !local_req && ce;
  endsequence

  a_remote_lock: assert property (@(posedge clk) disable iff (srst)
    s_locked_req |=> !remote)
    else $error("remote entered while locked");
  a_write_local: assert property (@(posedge clk) disable iff (srst)
    ce && wr_req && !remote && wr_access != ACC_RO |=> !wr_ok && err_code == ERR_REMOTE)
    else $error("write accepted in local control");
  a_keep_value: assert property (@(posedge clk) disable iff (srst)
    ce && wr_req && verdict != ERR_NONE |=> setp[$past(wr_sel)] == $past(setp[wr_sel]))
    else $error("rejected write changed value");
  a_range_err: assert property (@(posedge clk) disable iff (srst)
    ce && wr_req && remote && wr_access != ACC_RO && wr_kind == KIND_SET
    && wr_value > CODE_SET_MAX |=> err_pulse && err_code == ERR_RANGE)
    else $error("over range code not flagged");
  a_ovt_span: assert property (@(posedge clk) disable iff (srst)
    ce && wr_req && remote && wr_access != ACC_RO && wr_kind == KIND_OVT && !ovt_alt
    && wr_value <= CODE_OVT_MAX |=> wr_ok)
    else $error("threshold code refused");
  a_text_route: assert property (@(posedge clk) disable iff (srst)
    ce && rx_valid && rx_first && !rx_tcp && rx_byte >= TEXT_FIRST_MIN
    |=> text_valid && !bin_valid)
    else $error("text byte not routed");
  a_addr_error: assert property (@(posedge clk) disable iff (srst)
    ce && rx_valid && rx_first && !rx_tcp && rx_byte != SLAVE_ADDR
    && rx_byte < TEXT_FIRST_MIN |=> err_pulse && !bin_valid && !text_valid)
    else $error("bad first byte not flagged");
  a_tcp_text: assert property (@(posedge clk) disable iff (srst)
    ce && rx_valid && rx_tcp |=> !text_valid)
    else $error("text routed from tcp");
  a_no_push: assert property (@(posedge clk) disable iff (srst)
    ce ##1 txt_err_valid |-> $past(err_query))
    else $error("text error pushed unasked");
  a_out_half: assert property (@(posedge clk) disable iff (srst)
    ce && !wr_req ##1 ce |=> out_code == {1'b0, $past(setp[0], 2) >> 1} || $past(wr_req))
    else $error("output code not halved");
endmodule : rspfe_top

/* File: rspfe_top_bench.sv */
/*
  Self-checking bench for the front end, with the host model on the byte side.
  Assumes a single 125 MHz clock; the clock enable is held high except in the freeze check.
*/
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s expected %h seen %h", n, e, g); end end
module rspfe_top_bench
  import rspfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 0, srst = 1, ce = 1, go = 0, slow = 0, rx_tcp = 0, tcp_fitted = 0;
  logic [7:0] lead = 8'h00;
  logic [15:0] word = 16'h0000, tcp_port = 16'h0000, wr_value = 16'h0000;
  logic [15:0] lim_min = 16'h0000, lim_max = 16'hFFFF;
  logic [2:0] tcp_hdr_len = 3'h0;
  logic wr_req = 0, rd_req = 0, remote_req = 0, local_req = 0, remote_lock = 0;
  logic ovt_alt = 0, err_query = 0;
  logic [1:0] wr_sel = 0, wr_kind = 0, wr_access = 0, rd_sel = 0;
  logic rx_valid, rx_first, rx_last, busy, remote, text_valid, text_last, bin_valid;
  logic bin_last, err_pulse, wr_ok, rd_valid, txt_err_valid;
  logic [7:0] rx_byte, text_byte, bin_byte;
  logic [3:0] err_code, txt_err_code;
  logic [15:0] rd_data, out_code;
  int error_cnt = 0;
  int compares = 0;

  // Free running clock, 8 ns period.
  initial
  begin
    forever #4 clk = ~clk;
  end

  rspfe_host i_rspfe_host (.clk(clk), .srst(srst), .go(go), .slow(slow), .lead(lead),
    .word(word), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_first(rx_first),
    .rx_last(rx_last), .busy(busy));

  rspfe_top i_rspfe_top (.clk(clk), .srst(srst), .ce(ce), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_first(rx_first), .rx_last(rx_last), .rx_tcp(rx_tcp),
    .tcp_port(tcp_port), .tcp_hdr_len(tcp_hdr_len), .tcp_fitted(tcp_fitted),
    .wr_req(wr_req), .wr_sel(wr_sel), .wr_kind(wr_kind), .wr_access(wr_access),
    .wr_value(wr_value), .rd_req(rd_req), .rd_sel(rd_sel), .remote_req(remote_req),
    .local_req(local_req), .remote_lock(remote_lock), .ovt_alt(ovt_alt),
    .lim_min(lim_min), .lim_max(lim_max), .err_query(err_query), .remote(remote),
    .text_valid(text_valid), .text_byte(text_byte), .text_last(text_last),
    .bin_valid(bin_valid), .bin_byte(bin_byte), .bin_last(bin_last),
    .err_pulse(err_pulse), .err_code(err_code), .wr_ok(wr_ok), .rd_valid(rd_valid),
    .rd_data(rd_data), .txt_err_valid(txt_err_valid), .txt_err_code(txt_err_code),
    .out_code(out_code));

  task automatic stop_test;
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // Sends one telegram and counts what comes out on each path.
  task automatic route(input logic [7:0] ld, input logic tcp, input logic [15:0] port,
                       input logic [2:0] hdr, input logic fit, input logic sl,
                       input int eb, input int et, input logic ee, input logic [3:0] code);
    int nb, nt, k;
    logic ne;
    logic [3:0] lc;
    logic [23:0] fw;
    logic lf;
    fw = 24'h000000;
    lf = 1'b0;
    nb = 0;
    nt = 0;
    ne = 0;
    lc = ERR_NONE;
    @(posedge clk);
    lead <= ld;
    word <= 16'hA55A;
    rx_tcp <= tcp;
    tcp_port <= port;
    tcp_hdr_len <= hdr;
    tcp_fitted <= fit;
    slow <= sl;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 12; k++)
    begin
      @(posedge clk);
      #1;
      nb += (bin_valid === 1'b1);
      nt += (text_valid === 1'b1);
      if (bin_valid === 1'b1 || text_valid === 1'b1)
      begin
        fw = {fw[15:0], (bin_valid === 1'b1) ? bin_byte : text_byte};
        lf = (bin_valid === 1'b1) ? bin_last : text_last;
      end
      if (err_pulse === 1'b1)
      begin
        ne = 1'b1;
        lc = err_code;
      end
    end
    if (busy !== 1'b0)
    begin
      error_cnt++;
      stop_test();
    end
    `CHK("bin count", eb, nb)
    `CHK("text count", et, nt)
    `CHK("error seen", ee, ne)
    if (code != ERR_NONE) `CHK("err_code", code, lc)
    if (eb + et == 3)
    begin
      `CHK("forwarded bytes", {ld, 16'hA55A}, fw)
      `CHK("last mark", 1'b1, lf)
    end
  endtask : route

  // One write word; a refusal must raise the error pulse instead of wr_ok.
  task automatic wr(input logic [1:0] s, input logic [1:0] k, input logic [1:0] a,
                    input logic [15:0] v, input logic [3:0] code);
    @(posedge clk);
    wr_req <= 1'b1;
    wr_sel <= s;
    wr_kind <= k;
    wr_access <= a;
    wr_value <= v;
    @(posedge clk);
    wr_req <= 1'b0;
    #1;
    `CHK("wr_ok", code == ERR_NONE, wr_ok)
    `CHK("err_pulse", code != ERR_NONE, err_pulse)
    if (code != ERR_NONE) `CHK("err_code", code, err_code)
  endtask : wr

  task automatic rd(input logic [1:0] s, input logic [15:0] e);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_sel <= s;
    @(posedge clk);
    rd_req <= 1'b0;
    #1;
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", e, rd_data)
  endtask : rd

  task automatic rem(input logic r, input logic l, input logic lk, input logic e);
    @(posedge clk);
    remote_req <= r;
    local_req <= l;
    remote_lock <= lk;
    @(posedge clk);
    remote_req <= 1'b0;
    local_req <= 1'b0;
    #1;
    `CHK("remote", e, remote)
  endtask : rem

  // With the enable low a remote request must not set remote.
  task automatic frozen;
    @(posedge clk);
    ce <= 1'b0;
    remote_req <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    remote_req <= 1'b0;
    #1;
    `CHK("remote frozen", 1'b0, remote)
  endtask : frozen

  // A refused write while a text string is in flight is queued, and err_pulse fires too.
  task automatic text_queue;
    fork
      route(8'h2A, 0, 16'h0000, 3'h0, 0, 1, 0, 3, 1, ERR_REMOTE);
      begin
        repeat (3) @(posedge clk);
        wr(2'h0, KIND_SET, ACC_RW, 16'h2000, ERR_REMOTE);
      end
    join
  endtask : text_queue

  // One error query; the queue is read and cleared by it.
  task automatic query(input logic [3:0] e);
    @(posedge clk);
    err_query <= 1'b1;
    @(posedge clk);
    err_query <= 1'b0;
    #1;
    `CHK("txt_err_valid", 1'b1, txt_err_valid)
    `CHK("txt_err_code", e, txt_err_code)
  endtask : query

  // Main sequence; the lock is left up after its scenario only for one call.
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK("remote", 1'b0, remote)
    `CHK("out_code", 16'h0000, out_code)
    route(8'h00, 0, 16'h0000, 3'h0, 0, 0, 3, 0, 0, ERR_NONE);
    route(8'h01, 0, 16'h0000, 3'h0, 0, 1, 0, 0, 1, ERR_ADDR);
    route(8'h29, 0, 16'h0000, 3'h0, 0, 0, 0, 0, 1, ERR_ADDR);
    route(8'h2A, 0, 16'h0000, 3'h0, 0, 1, 0, 3, 0, ERR_NONE);
    route(8'hFF, 0, 16'h0000, 3'h0, 0, 0, 0, 3, 0, ERR_NONE);
    route(8'h00, 1, TCP_REG_PORT, 3'h6, 1, 0, 3, 0, 0, ERR_NONE);
    route(8'h00, 1, TCP_REG_PORT, 3'h7, 1, 1, 3, 0, 0, ERR_NONE);
    route(8'h00, 1, 16'h01F7, 3'h6, 1, 0, 0, 0, 1, ERR_NONE);
    route(8'h00, 1, TCP_REG_PORT, 3'h6, 0, 0, 0, 0, 1, ERR_NONE);
    route(8'h00, 1, TCP_REG_PORT, 3'h5, 1, 0, 0, 0, 1, ERR_LENGTH);
    route(8'h2A, 1, TCP_REG_PORT, 3'h6, 1, 0, 0, 0, 1, ERR_TEXT_TCP);
    wr(2'h0, KIND_SET, ACC_RW, 16'h1234, ERR_REMOTE);
    rd(2'h0, 16'h0000);
    rem(1, 0, 1, 0);
    rem(1, 0, 0, 1);
    wr(2'h0, KIND_SET, ACC_RW, 16'hCCCC, ERR_NONE);
    rd(2'h0, 16'hCCCC);
    `CHK("out_code", 16'h6666, out_code)
    wr(2'h1, KIND_SET, ACC_RW, 16'((32'(CODE_FULL) * 32'd3150 + 32'd1750) / 32'd3500),
       ERR_NONE);
    rd(2'h1, 16'hB851);
    wr(2'h1, KIND_SET, ACC_RW, 16'hD0E5, ERR_NONE);
    wr(2'h1, KIND_SET, ACC_RW, 16'hD0E6, ERR_RANGE);
    rd(2'h1, 16'hD0E5);
    wr(2'h2, KIND_OVT, ACC_RW, 16'hE147, ERR_NONE);
    wr(2'h2, KIND_OVT, ACC_RW, 16'hE148, ERR_RANGE);
    @(posedge clk);
    ovt_alt <= 1'b1;
    lim_min <= 16'h1000;
    lim_max <= 16'h8000;
    wr(2'h2, KIND_OVT, ACC_RW, 16'hD2F2, ERR_RANGE);
    wr(2'h2, KIND_OVT, ACC_RW, 16'hD2F1, ERR_NONE);
    wr(2'h3, KIND_SET, ACC_RW, 16'h8001, ERR_LIMIT);
    wr(2'h3, KIND_SET, ACC_RW, 16'h0FFF, ERR_LIMIT);
    wr(2'h3, KIND_SET, ACC_WO, 16'h8000, ERR_NONE);
    wr(2'h3, KIND_COIL, ACC_RW, COIL_TRUE, ERR_NONE);
    wr(2'h3, KIND_COIL, ACC_RW, 16'h0001, ERR_RANGE);
    wr(2'h3, KIND_RAW, ACC_RO, 16'h5555, ERR_ACCESS);
    rd(2'h3, COIL_TRUE);
    rem(1, 1, 0, 0);
    wr(2'h0, KIND_SET, ACC_RW, 16'h0100, ERR_REMOTE);
    frozen();
    text_queue();
    query(ERR_REMOTE);
    query(ERR_NONE);
    stop_test();
  end
endmodule : rspfe_top_bench
